/* File: hw/irq_bank_params.svh */
// Constants of the peripheral interrupt enable and flag bank.
// Assumes a single 100 MHz clock and an AHB-Lite register port.
//
// Overview of operation
// - No peripheral request reaches the core while master enable is clear.
// - A flag sets on its event whatever the enable bits say.
// - Enable 2: osc fail, cmp2, cmp1, empty, collision, tmr6, tmr4, cap2.
// - Enable 3: empty, numeric osc, shutdown, zero cross, logic cells 4-1.
// - Req 1: gate, converter, rx, tx, sync, cap1, tmr2, tmr1; rx/tx RO.
// - Request register 2 matches enable register 2 bit for bit.
// - Request register 3 matches enable register 3 bit for bit.
// - A flag that reads 1 is pending and a flag that reads 0 is not.
// - Unimplemented bits read zero and ignore writes.
// - All enable and flag bits clear to zero on every reset; the live rx and tx bits of Req 1 follow their peripherals instead.
// - Enable register 1 matches request register 1 bit for bit.
// - A clear global enable blocks every request to the core.
// - Bit 6 of the core control register is the peripheral master enable.
`ifndef IRQ_BANK_PARAMS_SVH
`define IRQ_BANK_PARAMS_SVH

// ----------------------------------------------------------------
// Register word indices; the byte address is four times the index
// ----------------------------------------------------------------
`define OFS_CORE_CTRL   4'h0
`define OFS_EN1         4'h1
`define OFS_EN2         4'h2
`define OFS_EN3         4'h3
`define OFS_REQ1        4'h4
`define OFS_REQ2        4'h5
`define OFS_REQ3        4'h6
`define OFS_STATUS      4'h7
`define OFS_MASK        4'h8
`define REG_COUNT       9

// ----------------------------------------------------------------
// Bit masks and field positions
// ----------------------------------------------------------------
`define MASK_ALL        8'hFF
`define MASK_EN2        8'hEF
`define MASK_EN3        8'h7F
`define MASK_REQ1_WR    8'hCF
`define MASK_CORE_WR    8'hC0
`define MASK_STATUS     8'h03
`define BIT_GLOBAL_EN   7
`define BIT_PERIPH_EN   6
`define BIT_ST_SET      0
`define BIT_ST_CLEAR    1
`define RESET_BYTE      8'h00

`endif

/* File: hw/irq_bank_pkg.sv */
// Types shared by the interrupt bank files.
// Assumes the constants header is compiled alongside.
package irq_bank_pkg;

  typedef logic [7:0] byte_t;

  typedef enum logic [1:0] {
    PH_IDLE,
    PH_WRITE,
    PH_READ
  } bus_phase_t;

endpackage

/* File: hw/flag_byte.sv */
// One byte of sticky request flags.
// Assumes set pulses are synchronous to clk.
`include "irq_bank_params.svh"

module flag_byte
  import irq_bank_pkg::*;
#(
  parameter byte_t WR_MASK  = 8'hFF,
  parameter byte_t IMP_MASK = 8'hFF
) (
  input  wire logic  clk,
  input  wire logic  rst,
  input  wire byte_t set_in,
  input  wire logic  wr_en,
  input  wire byte_t wr_data,
  output byte_t      flags
);

  typedef struct packed {
    byte_t flags;
  } state_t;

  state_t s_q;
  state_t s_d;

  // Per bit: event sets, software write of zero clears writable bits
  always_comb begin
    s_d = s_q;
    for (int i = 0; i < 8; i++) begin
      if (IMP_MASK[i]) begin
        if (set_in[i]) begin
          s_d.flags[i] = 1'b1;
        end else if (wr_en && WR_MASK[i]) begin
          s_d.flags[i] = wr_data[i];
        end
      end else begin
        s_d.flags[i] = 1'b0;
      end
    end
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign flags = s_q.flags;

endmodule // flag_byte

/* File: hw/irq_bank.sv */
// Peripheral interrupt enable and flag bank with AHB-Lite registers.
// Assumes one clock, asynchronous reset, and peripheral event pulses
// synchronous to clk.
//
// Added by the designer: the AHB-Lite slave port and the placing of the registers.
`include "irq_bank_params.svh"

module irq_bank
  import irq_bank_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire byte_t       req1_set,
  input  wire byte_t       req2_set,
  input  wire byte_t       req3_set,
  input  wire logic        serial_rx_irq_flag,
  input  wire logic        serial_tx_irq_flag,
  output logic             core_irq,
  output logic             bank_irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    bus_phase_t  phase;
    logic [3:0]  addr;
    byte_t       core_ctrl;
    byte_t       en1;
    byte_t       en2;
    byte_t       en3;
    byte_t       status;
    byte_t       mask;
    logic        prev_req;
    logic [31:0] rdata;
    logic        core_irq;
    logic        bank_irq;
  } state_t;

  state_t s_q;
  state_t s_d;

  byte_t req1;
  byte_t req2;
  byte_t req3;
  byte_t req1_raw;
  byte_t wbyte;
  logic  wr_req1;
  logic  wr_req2;
  logic  wr_req3;
  logic  periph_req;
  logic  comb_req;
  byte_t st_set;
  logic  addr_ok;

  // Decode of a byte address into a word-aligned register index
  function automatic logic [3:0] reg_index(input logic [31:0] a);
    reg_index = a[5:2];
  endfunction

  // Mask applied to writes for each control, enable and mask register index
  function automatic byte_t wr_mask(input logic [3:0] idx);
    case (idx)
      `OFS_CORE_CTRL: wr_mask = `MASK_CORE_WR;
      `OFS_EN1:       wr_mask = `MASK_ALL;
      `OFS_EN2:       wr_mask = `MASK_EN2;
      `OFS_EN3:       wr_mask = `MASK_EN3;
      `OFS_MASK:      wr_mask = `MASK_STATUS;
      default:        wr_mask = 8'h00;
    endcase
  endfunction

  assign wbyte   = hwdata[7:0];
  assign addr_ok = (haddr[31:6] == 26'h0) &&
                   (reg_index(haddr) < 4'(`REG_COUNT));
  assign wr_req1 = (s_q.phase == PH_WRITE) && (s_q.addr == `OFS_REQ1);
  assign wr_req2 = (s_q.phase == PH_WRITE) && (s_q.addr == `OFS_REQ2);
  assign wr_req3 = (s_q.phase == PH_WRITE) && (s_q.addr == `OFS_REQ3);

  // ----------------------------------------------------------------
  // Flag banks
  // ----------------------------------------------------------------
  // Request register 1: rx and tx follow their peripherals, read only
  flag_byte #(
    .WR_MASK  (`MASK_REQ1_WR),
    .IMP_MASK (`MASK_REQ1_WR)
  ) u_req1 (
    .clk     (clk),
    .rst     (rst),
    .set_in  (req1_set),
    .wr_en   (wr_req1),
    .wr_data (wbyte),
    .flags   (req1_raw)
  );

  // Live rx and tx flags merged in at bits 5 and 4
  assign req1 = {req1_raw[7:6], serial_rx_irq_flag, serial_tx_irq_flag,
                 req1_raw[3:0]};

  // Request register 2 mirrors enable register 2
  flag_byte #(
    .WR_MASK  (`MASK_EN2),
    .IMP_MASK (`MASK_EN2)
  ) u_req2 (
    .clk     (clk),
    .rst     (rst),
    .set_in  (req2_set),
    .wr_en   (wr_req2),
    .wr_data (wbyte),
    .flags   (req2)
  );

  // Request register 3 mirrors enable register 3
  flag_byte #(
    .WR_MASK  (`MASK_EN3),
    .IMP_MASK (`MASK_EN3)
  ) u_req3 (
    .clk     (clk),
    .rst     (rst),
    .set_in  (req3_set),
    .wr_en   (wr_req3),
    .wr_data (wbyte),
    .flags   (req3)
  );

  // ----------------------------------------------------------------
  // Request combining
  // ----------------------------------------------------------------
  // OR of flag and enable pairs, gated by master and global enables
  assign periph_req = |(req1 & s_q.en1) | |(req2 & s_q.en2) |
                      |(req3 & s_q.en3);
  assign comb_req   = periph_req &
                      s_q.core_ctrl[`BIT_PERIPH_EN] &
                      s_q.core_ctrl[`BIT_GLOBAL_EN];

  // Bank events: request rises and request falls
  always_comb begin
    st_set = 8'h00;
    st_set[`BIT_ST_SET]   = comb_req & ~s_q.prev_req;
    st_set[`BIT_ST_CLEAR] = ~comb_req & s_q.prev_req;
  end

  // ----------------------------------------------------------------
  // Bus slave and registers
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.prev_req = comb_req;
    s_d.core_irq = comb_req;
    s_d.phase = PH_IDLE;
    // Data phase of a write lands here
    if (s_q.phase == PH_WRITE) begin
      case (s_q.addr)
        `OFS_CORE_CTRL: s_d.core_ctrl = (s_q.core_ctrl & ~`MASK_CORE_WR) |
                                        (wbyte & `MASK_CORE_WR);
        `OFS_EN1:       s_d.en1 = wbyte;
        `OFS_EN2:       s_d.en2 = wbyte & wr_mask(s_q.addr);
        `OFS_EN3:       s_d.en3 = wbyte & wr_mask(s_q.addr);
        `OFS_MASK:      s_d.mask = wbyte & `MASK_STATUS;
        default:        s_d.mask = s_d.mask;
      endcase
    end
    // Sticky status: set wins over write-one-to-clear
    s_d.status = s_q.status;
    if ((s_q.phase == PH_WRITE) && (s_q.addr == `OFS_STATUS)) begin
      s_d.status = s_q.status & ~(wbyte & `MASK_STATUS);
    end
    s_d.status = s_d.status | st_set;
    s_d.bank_irq = |(s_d.status & s_q.mask);
    // Address phase capture
    if (hsel && hready && htrans[1]) begin
      s_d.addr = addr_ok ? reg_index(haddr) : 4'hF;
      s_d.phase = hwrite ? PH_WRITE : PH_READ;
      s_d.rdata = 32'h0;
      case (reg_index(haddr))
        `OFS_CORE_CTRL: s_d.rdata[7:0] = s_q.core_ctrl;
        `OFS_EN1:       s_d.rdata[7:0] = s_q.en1;
        `OFS_EN2:       s_d.rdata[7:0] = s_q.en2;
        `OFS_EN3:       s_d.rdata[7:0] = s_q.en3;
        `OFS_REQ1:      s_d.rdata[7:0] = req1;
        `OFS_REQ2:      s_d.rdata[7:0] = req2;
        `OFS_REQ3:      s_d.rdata[7:0] = req3;
        `OFS_STATUS:    s_d.rdata[7:0] = s_q.status;
        `OFS_MASK:      s_d.rdata[7:0] = s_q.mask;
        default:        s_d.rdata = 32'h0;
      endcase
      if (!addr_ok) begin
        s_d.rdata = 32'h0;
      end
    end
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign hrdata    = s_q.rdata;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign core_irq  = s_q.core_irq;
  assign bank_irq  = s_q.bank_irq;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_master_off;
    !s_q.core_ctrl[`BIT_PERIPH_EN];
  endsequence

  property p_master_blocks;
    @(posedge clk) disable iff (rst)
      s_master_off |=> !core_irq;
  endproperty
  a_master_blocks: assert property (p_master_blocks)
    else $error("irq passed with master enable clear");

  property p_global_blocks;
    @(posedge clk) disable iff (rst)
      !s_q.core_ctrl[`BIT_GLOBAL_EN] |=> !core_irq;
  endproperty
  a_global_blocks: assert property (p_global_blocks)
    else $error("irq passed with global enable clear");

  property p_flag_sets;
    @(posedge clk) disable iff (rst)
      req2_set[0] |=> req2[0];
  endproperty
  a_flag_sets: assert property (p_flag_sets)
    else $error("flag did not set on event");

  property p_set_beats_clear;
    @(posedge clk) disable iff (rst)
      (req3_set[0] && wr_req3 && !wbyte[0]) |=> req3[0];
  endproperty
  a_set_beats_clear: assert property (p_set_beats_clear)
    else $error("clearing write beat a set event");

  property p_holes_zero;
    @(posedge clk) disable iff (rst)
      !s_q.en2[4] && !s_q.en3[7] && !req2[4] && !req3[7];
  endproperty
  a_holes_zero: assert property (p_holes_zero)
    else $error("unimplemented bit set");

  property p_combine;
    @(posedge clk) disable iff (rst)
      (s_q.core_ctrl[7:6] == 2'b11) ##0 (|(req2 & s_q.en2)) |=> core_irq;
  endproperty
  a_combine: assert property (p_combine)
    else $error("enabled pending flag did not raise irq");

  property p_rx_live;
    @(posedge clk) disable iff (rst)
      req1[5] == serial_rx_irq_flag && req1[4] == serial_tx_irq_flag;
  endproperty
  a_rx_live: assert property (p_rx_live)
    else $error("rx or tx flag not following its source");

  property p_clear_zero;
    @(posedge clk) disable iff (rst)
      (wr_req1 && !wbyte[0] && !req1_set[0]) |=> !req1[0];
  endproperty
  a_clear_zero: assert property (p_clear_zero)
    else $error("flag did not clear on write of zero");

  // Data phase of a write to one register index
  sequence s_wr_data(logic [3:0] idx);
    (s_q.phase == PH_WRITE) && (s_q.addr == idx);
  endsequence

  // Enable registers take the written byte through their masks
  property p_en1_write;
    @(posedge clk) disable iff (rst)
      s_wr_data(`OFS_EN1) |=> (s_q.en1 == $past(wbyte));
  endproperty
  a_en1_write: assert property (p_en1_write)
    else $error("enable register 1 did not take the written byte");

  property p_en2_write;
    @(posedge clk) disable iff (rst)
      s_wr_data(`OFS_EN2) |=> (s_q.en2 == ($past(wbyte) & `MASK_EN2));
  endproperty
  a_en2_write: assert property (p_en2_write)
    else $error("enable register 2 write wrong");

  property p_en3_write;
    @(posedge clk) disable iff (rst)
      s_wr_data(`OFS_EN3) |=> (s_q.en3 == ($past(wbyte) & `MASK_EN3));
  endproperty
  a_en3_write: assert property (p_en3_write)
    else $error("enable register 3 write wrong");

  // Stored bits under the live serial flags never set
  property p_req1_ro;
    @(posedge clk) disable iff (rst)
      req1_raw[5:4] == 2'b00;
  endproperty
  a_req1_ro: assert property (p_req1_ro)
    else $error("read-only serial flag was stored");

  // Every set pulse of request register 3 lands in its implemented flag bit
  property p_req3_sets;
    @(posedge clk) disable iff (rst)
      (|req3_set) |=> ((req3 & $past(req3_set)) ==
                       ($past(req3_set) & `MASK_EN3));
  endproperty
  a_req3_sets: assert property (p_req3_sets)
    else $error("request register 3 missed a set pulse");

  // A pending flag stays pending until software writes its register
  property p_flag_holds;
    @(posedge clk) disable iff (rst)
      (req2[1] && !wr_req2) |=> req2[1];
  endproperty
  a_flag_holds: assert property (p_flag_holds)
    else $error("pending flag dropped without a write");

  // The core request needs both enables one cycle earlier
  property p_irq_needs_enables;
    @(posedge clk) disable iff (rst)
      core_irq |-> $past(s_q.core_ctrl[`BIT_PERIPH_EN] &&
                         s_q.core_ctrl[`BIT_GLOBAL_EN]);
  endproperty
  a_irq_needs_enables: assert property (p_irq_needs_enables)
    else $error("irq raised without both enables");

  // The core request needs an enabled pending flag
  property p_irq_needs_flag;
    @(posedge clk) disable iff (rst)
      core_irq |-> $past(periph_req);
  endproperty
  a_irq_needs_flag: assert property (p_irq_needs_flag)
    else $error("irq raised without an enabled flag");

  // Status bit 0 records every rise of the combined request
  property p_status_rise;
    @(posedge clk) disable iff (rst)
      (comb_req && !s_q.prev_req) |=> s_q.status[`BIT_ST_SET];
  endproperty
  a_status_rise: assert property (p_status_rise)
    else $error("request rise not recorded in status");

  // Every enable and flag except the live rx and tx bits is clear while reset is held
  property p_reset_clear;
    @(posedge clk)
      rst |-> (s_q.core_ctrl == 8'h00) && (s_q.en1 == 8'h00) &&
              (s_q.en2 == 8'h00) && (s_q.en3 == 8'h00) &&
              (req1_raw == 8'h00) && (req2 == 8'h00) &&
              (req3 == 8'h00) && !core_irq && !bank_irq;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("register not clear during reset");

endmodule // irq_bank

/* File: test/periph_model.sv */
// Peripheral side model: turns bench requests into set pulses.
// Assumes go, sel and bits change just after a rising clk edge.
module periph_model
  import irq_bank_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       go,
  input  wire logic [1:0] sel,
  input  wire byte_t      bits,
  output byte_t           req1_set,
  output byte_t           req2_set,
  output byte_t           req3_set
);
  // The set line chosen by sel carries bits one cycle after go, for as long as go is held, then falls back to 0
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      req1_set <= 8'h00;
      req2_set <= 8'h00;
      req3_set <= 8'h00;
    end else begin
      req1_set <= (go && sel == 2'h1) ? bits : 8'h00;
      req2_set <= (go && sel == 2'h2) ? bits : 8'h00;
      req3_set <= (go && sel == 2'h3) ? bits : 8'h00;
    end
  end
endmodule // periph_model

/* File: test/irq_bank_tb.sv */
// Self-checking bench for the interrupt enable and flag bank.
// Assumes the design's zero-wait AHB-Lite slave and periph_model.
module irq_bank_tb;
  import irq_bank_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, hsel, hwrite, hreadyout, hresp, go, rx, tx, rd_ph;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans, sel;
  logic [2:0]  hsize;
  byte_t       bits, r1, r2, r3;
  logic        core_irq, bank_irq;
  wire logic   hready = hreadyout;
  logic [31:0] exp_q [$];
  int          fail_count, n_tests, seed, cyc, r;
  byte_t       msk [0:6] = '{8'hC0, 8'hFF, 8'hEF, 8'h7F, 8'hCF, 8'hEF, 8'h7F};
  logic [7:0]  core_v [0:3] = '{8'h00, 8'h80, 8'h40, 8'hC0};

  irq_bank u_dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .req1_set(r1), .req2_set(r2), .req3_set(r3), .serial_rx_irq_flag(rx),
    .serial_tx_irq_flag(tx), .core_irq(core_irq), .bank_irq(bank_irq));
  periph_model u_periph (.clk(clk), .rst(rst), .go(go), .sel(sel),
    .bits(bits), .req1_set(r1), .req2_set(r2), .req3_set(r3));

  // Clock at 100 MHz
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] ba(input int i);
    ba = 32'(i) << 2;
  endfunction

  // One AHB-Lite single transfer; reads leave a note for the monitor
  task automatic bus(input logic w, input logic [31:0] a, d, e);
    @(posedge clk);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    rd_ph <= ~w;
    if (!w) exp_q.push_back(e);
    do @(posedge clk); while (hready !== 1'b1);
    rd_ph <= 1'b0;
  endtask

  task automatic wr(input int i, input logic [31:0] d);
    bus(1'b1, ba(i), d, 32'h0);
  endtask

  task automatic rd(input int i, input logic [31:0] e);
    bus(1'b0, ba(i), 32'h0, e);
  endtask

  task automatic pulse(input logic [1:0] s, input byte_t b);
    @(posedge clk);
    go <= 1'b1;
    sel <= s;
    bits <= b;
    @(posedge clk);
    go <= 1'b0;
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Monitor takes the oldest note when read data stands
  always @(posedge clk) begin
    if (rd_ph === 1'b1 && hready === 1'b1) begin
      chk(hrdata, exp_q.pop_front());
      chk({31'h0, hresp}, 32'h0);
    end
  end

  // Cycle ceiling against a hang
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      finish_test;
    end
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    seed = 62195;
    {hsel, hwrite, go, rx, tx, rd_ph} = '0;
    haddr = '0;
    hwdata = '0;
    htrans = 2'h0;
    hsize = 3'h2;
    sel = 2'h0;
    bits = 8'h00;
    rst = 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    hsel <= 1'b1;
    for (int i = 0; i < 9; i++) rd(i, 32'h0);
    rd(9, 32'h0);
    $display("test reset values done");
    // Random writes show writable and empty bit positions
    for (int i = 0; i < 7; i++) begin
      r = $random(seed);
      wr(i, r);
      rd(i, {24'h0, r[7:0] & msk[i]});
    end
    for (int i = 0; i < 7; i++) wr(i, 32'h0);
    for (int i = 4; i < 7; i++) rd(i, 32'h0);
    $display("test register access done");
    // Serial flags mirror their live levels only
    rx <= 1'b1;
    rd(4, 32'h20);
    rx <= 1'b0;
    tx <= 1'b1;
    rd(4, 32'h10);
    tx <= 1'b0;
    $display("test serial mirror done");
    // Flags set with every enable clear
    for (int s = 1; s < 4; s++) begin
      pulse(2'(s), 8'hFF);
      rd(s + 3, {24'h0, msk[s + 3]});
      chk({31'h0, core_irq}, 32'h0);
      wr(s + 3, 32'h0);
    end
    $display("test flags set done");
    // Bit 0 pair of each register under each combination of the two enables
    for (int s = 1; s < 4; s++) begin
      wr(s + 3, 32'h0);
      pulse(2'(s), 8'h01);
      wr(s, 32'h1);
      for (int k = 0; k < 4; k++) begin
        wr(0, {24'h0, core_v[k]});
        repeat (3) @(posedge clk);
        chk({31'h0, core_irq}, {31'h0, k == 3});
      end
      wr(s + 3, 32'h0);
      repeat (3) @(posedge clk);
      chk({31'h0, core_irq}, 32'h0);
      wr(s, 32'h0);
    end
    wr(0, 32'hFF);
    rd(0, 32'hC0);
    $display("test gating done");
    // Event in the same edge as a clearing write survives
    fork
      wr(6, 32'h0);
      pulse(2'h3, 8'h05);
    join
    rd(6, 32'h05);
    wr(6, 32'h0);
    $display("test set over clear done");
    // Status, mask and the bank interrupt line
    wr(1, 32'h0);
    wr(7, 32'h3);
    rd(7, 32'h0);
    wr(8, 32'h1);
    rd(8, 32'h1);
    chk({31'h0, bank_irq}, 32'h0);
    wr(1, 32'h1);
    pulse(2'h1, 8'h01);
    // Flag lands one edge after the pulse, status one edge later
    repeat (2) @(posedge clk);
    rd(7, 32'h1);
    chk({31'h0, bank_irq}, 32'h1);
    wr(7, 32'h1);
    wr(4, 32'h0);
    rd(7, 32'h2);
    chk({31'h0, bank_irq}, 32'h0);
    wr(7, 32'h2);
    rd(7, 32'h0);
    $display("test status and mask done");
    // Reset in mid-run clears enables and flags again
    wr(1, 32'hFF);
    pulse(2'h2, 8'hFF);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 9; i++) rd(i, 32'h0);
    chk({31'h0, core_irq}, 32'h0);
    chk({31'h0, bank_irq}, 32'h0);
    $display("test mid-run reset done");
    finish_test;
  end
endmodule // irq_bank_tb
